// ===== include/pcd_pkg.sv
/*
  Shared constants, types and decode functions for the playback clock chain
  configuration registers. Assumes a single 100 MHz clock domain and a register
  access port driven by the serial control port decoder on the same clock.
*/
package pcd_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PCD_ADDR_W = 7;
  localparam int PCD_DATA_W = 8;

  // ==========================================================================
  // Register offsets on the default page
  // ==========================================================================
  localparam logic [6:0] PCD_ADDR_FRAC_HI = 7'h07;
  localparam logic [6:0] PCD_ADDR_FRAC_LO = 7'h08;
  localparam logic [6:0] PCD_ADDR_RSVD_A = 7'h09;
  localparam logic [6:0] PCD_ADDR_RSVD_B = 7'h0a;
  localparam logic [6:0] PCD_ADDR_COARSE = 7'h0b;
  localparam logic [6:0] PCD_ADDR_FINE = 7'h0c;
  localparam logic [6:0] PCD_ADDR_OSR_HI = 7'h0d;
  localparam logic [6:0] PCD_ADDR_OSR_LO = 7'h0e;
  localparam logic [6:0] PCD_ADDR_INSTR = 7'h0f;
  localparam logic [6:0] PCD_ADDR_INTERP = 7'h10;
  localparam logic [6:0] PCD_ADDR_RSVD_C = 7'h11;

  // ==========================================================================
  // Reset values and field masks
  // ==========================================================================
  localparam logic [7:0] PCD_RST_FRAC_HI = 8'h00;
  localparam logic [7:0] PCD_RST_FRAC_LO = 8'h00;
  localparam logic [7:0] PCD_RST_DIV = 8'h01;
  localparam logic [7:0] PCD_RST_OSR_HI = 8'h00;
  localparam logic [7:0] PCD_RST_OSR_LO = 8'h80;
  localparam logic [7:0] PCD_RST_INSTR = 8'h80;
  localparam logic [7:0] PCD_RST_INTERP = 8'h08;
  localparam logic [7:0] PCD_MASK_FRAC_HI = 8'h3f;
  localparam logic [7:0] PCD_MASK_OSR_HI = 8'h03;
  localparam logic [7:0] PCD_MASK_INTERP = 8'h0f;
  localparam logic [7:0] PCD_MASK_DIV_RATIO = 8'h7f;
  localparam int PCD_DIV_PWR_BIT = 7;

  // ==========================================================================
  // Decoded values for an all-zero field
  // ==========================================================================
  localparam logic [7:0] PCD_DIV_ZERO_RATIO = 8'h80;
  localparam logic [10:0] PCD_OSR_ZERO_RATIO = 11'h400;
  localparam logic [10:0] PCD_INSTR_ZERO_COUNT = 11'h400;
  localparam logic [4:0] PCD_INTERP_ZERO_RATIO = 5'h10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } pcd_wr_t;

  typedef struct packed {
    logic pwr;
    logic [7:0] ratio;
  } pcd_div_t;

  typedef enum logic [0:0] {
    PCD_SPLIT_IDLE = 1'b0,
    PCD_SPLIT_ARMED = 1'b1
  } pcd_split_state_t;

  typedef struct packed {
    pcd_split_state_t state;
    logic [7:0] staged;
    logic [7:0] hi;
    logic [7:0] lo;
  } pcd_split_t;

  typedef struct packed {
    logic [7:0] coarse_reg;
    logic [7:0] fine_reg;
    logic [7:0] instr_reg;
    logic [7:0] interp_reg;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [13:0] frac;
    pcd_div_t coarse;
    pcd_div_t fine;
    logic [10:0] osr;
    logic [10:0] instr;
    logic [4:0] interp;
  } pcd_main_t;

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  function automatic pcd_div_t pcd_div_decode(input logic [7:0] r);
    pcd_div_t d;
    d.pwr = r[PCD_DIV_PWR_BIT];
    d.ratio = ((r & PCD_MASK_DIV_RATIO) == 8'h00) ? PCD_DIV_ZERO_RATIO : (r & PCD_MASK_DIV_RATIO);
    return d;
  endfunction : pcd_div_decode

  function automatic logic [10:0] pcd_osr_decode(input logic [7:0] hi, input logic [7:0] lo);
    logic [9:0] v;
    v = {hi[1:0], lo};
    return (v == 10'h000) ? PCD_OSR_ZERO_RATIO : {1'b0, v};
  endfunction : pcd_osr_decode

  function automatic logic [10:0] pcd_instr_decode(input logic [7:0] r);
    return (r == 8'h00) ? PCD_INSTR_ZERO_COUNT : {1'b0, r, 2'b00};
  endfunction : pcd_instr_decode

  function automatic logic [4:0] pcd_interp_decode(input logic [7:0] r);
    return (r[3:0] == 4'h0) ? PCD_INTERP_ZERO_RATIO : {1'b0, r[3:0]};
  endfunction : pcd_interp_decode

endpackage : pcd_pkg

// ===== verif/tb.sv
/*
  Self-checking testbench for the playback clock chain configuration registers.
  Assumes pcd_clock_regs from the design with its package, one 100 MHz clock and
  an asynchronous active-low reset; the bench drives the register port directly.
*/
module tb
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic page_zero_i = 1'b1;
  pcd_wr_t wr_i = '0;
  logic rd_en_i = 1'b0;
  logic [6:0] rd_addr_i = 7'h00;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic [13:0] frac_o;
  pcd_div_t coarse_o;
  pcd_div_t fine_o;
  logic [10:0] osr_o;
  logic [10:0] instr_o;
  logic [4:0] interp_o;
  int failures = 0;
  int checks = 0;
  logic [7:0] dv [4] = '{8'h80, 8'h7f, 8'h81, 8'h02};
  logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h80, 8'h08, 8'h00};

  pcd_clock_regs i_pcd_clock_regs (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .page_zero_i(page_zero_i),
    .wr_i(wr_i),
    .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .frac_o(frac_o),
    .coarse_o(coarse_o),
    .fine_o(fine_o),
    .osr_o(osr_o),
    .instr_o(instr_o),
    .interp_o(interp_o)
  );

  always #5 mclk_i = ~mclk_i;

  // ==========================================================================
  // Access and compare tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Write strobe stays up so that writes can follow back to back
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rd_en_i = 1'b0;
    wr_i = '{en: 1'b1, addr: a, data: d};
    @(posedge mclk_i);
    #1;
  endtask : wr

  task automatic idle(input int n);
    wr_i.en = 1'b0;
    rd_en_i = 1'b0;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
    end
  endtask : idle

  task automatic chk_rd(input logic [6:0] a, input logic [7:0] exp);
    wr_i.en = 1'b0;
    rd_en_i = 1'b1;
    rd_addr_i = a;
    @(posedge mclk_i);
    #1;
    checks++;
    if (rd_valid_o !== 1'b1 || rd_data_o !== exp) begin
      failures++;
      $display("ERROR %0t read of %h gave %h valid %b, expected %h", $time, a, rd_data_o, rd_valid_o, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : chk_out

  function automatic logic [8:0] div_exp(input logic [7:0] r);
    return {r[7], (r[6:0] == 7'h00) ? 8'h80 : {1'b0, r[6:0]}};
  endfunction : div_exp

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    // Reset values of every register in the window, reserved ones read zero
    for (int i = 0; i < 11; i++) begin
      chk_rd(7'(PCD_ADDR_FRAC_HI + i), rv[i]);
    end
    idle(1);
    chk_out({15'h0, rd_valid_o}, 16'h0000, "read valid after pulse");
    chk_out({8'h0, rd_data_o}, 16'h0000, "idle read data");
    chk_out({2'h0, frac_o}, 16'h0000, "reset fraction");
    chk_out({7'h0, coarse_o}, 16'h0001, "reset coarse divider");
    chk_out({7'h0, fine_o}, 16'h0001, "reset fine divider");
    chk_out({5'h0, osr_o}, 16'd128, "reset oversampling");
    chk_out({5'h0, instr_o}, 16'd512, "reset instruction count");
    chk_out({11'h0, interp_o}, 16'd8, "reset interpolation");

    // Divider power bit and ratio field, zero field meaning 128
    for (int i = 0; i < 4; i++) begin
      wr(PCD_ADDR_COARSE, dv[i]);
      wr(PCD_ADDR_FINE, dv[(i + 1) % 4]);
      chk_rd(PCD_ADDR_COARSE, dv[i]);
      chk_rd(PCD_ADDR_FINE, dv[(i + 1) % 4]);
      idle(2);
      chk_out({7'h0, coarse_o}, {7'h0, div_exp(dv[i])}, "coarse divider");
      chk_out({7'h0, fine_o}, {7'h0, div_exp(dv[(i + 1) % 4])}, "fine divider");
    end

    // Read and write in one cycle to one address returns the old value
    rd_en_i = 1'b1;
    rd_addr_i = PCD_ADDR_FINE;
    wr_i = '{en: 1'b1, addr: PCD_ADDR_FINE, data: 8'h55};
    @(posedge mclk_i);
    #1;
    chk_out({8'h0, rd_data_o}, {8'h0, dv[0]}, "read beside write");
    chk_rd(PCD_ADDR_FINE, 8'h55);

    // Fraction pair: committed together, reserved high bits dropped
    wr(PCD_ADDR_FRAC_HI, 8'hff);
    wr(PCD_ADDR_FRAC_LO, 8'ha5);
    chk_rd(PCD_ADDR_FRAC_HI, 8'h3f);
    chk_rd(PCD_ADDR_FRAC_LO, 8'ha5);
    chk_out({2'h0, frac_o}, 16'h3fa5, "paired fraction");
    // Intervening write discards the staged high part
    wr(PCD_ADDR_FRAC_HI, 8'h12);
    wr(PCD_ADDR_RSVD_A, 8'h00);
    wr(PCD_ADDR_FRAC_LO, 8'h34);
    chk_rd(PCD_ADDR_FRAC_HI, 8'h3f);
    idle(2);
    chk_out({2'h0, frac_o}, 16'h3f34, "broken fraction pair");
    // A write on another page also breaks the pair
    wr(PCD_ADDR_FRAC_HI, 8'h07);
    page_zero_i = 1'b0;
    wr(PCD_ADDR_COARSE, 8'h9f);
    page_zero_i = 1'b1;
    wr(PCD_ADDR_FRAC_LO, 8'h01);
    chk_rd(PCD_ADDR_COARSE, dv[3]);
    idle(2);
    chk_out({2'h0, frac_o}, 16'h3f01, "pair broken off page");
    // Repeated high write re-stages; last one wins
    wr(PCD_ADDR_FRAC_HI, 8'h05);
    wr(PCD_ADDR_FRAC_HI, 8'h06);
    wr(PCD_ADDR_FRAC_LO, 8'h00);
    idle(2);
    chk_out({2'h0, frac_o}, 16'h0600, "restaged fraction");

    // Oversampling ratio split over two registers
    wr(PCD_ADDR_OSR_HI, 8'hff);
    wr(PCD_ADDR_OSR_LO, 8'hff);
    chk_rd(PCD_ADDR_OSR_HI, 8'h03);
    chk_out({5'h0, osr_o}, 16'd1023, "oversampling maximum");
    wr(PCD_ADDR_OSR_HI, 8'h00);
    wr(PCD_ADDR_OSR_LO, 8'h00);
    idle(2);
    chk_out({5'h0, osr_o}, 16'd1024, "oversampling zero");
    wr(PCD_ADDR_OSR_HI, 8'h01);
    wr(PCD_ADDR_INTERP, 8'h04);
    wr(PCD_ADDR_OSR_LO, 8'h05);
    idle(2);
    chk_out({5'h0, osr_o}, 16'd5, "oversampling broken pair");
    chk_out({11'h0, interp_o}, 16'd4, "interpolation four");

    // Instruction count and interpolation field decode
    wr(PCD_ADDR_INSTR, 8'h00);
    idle(2);
    chk_out({5'h0, instr_o}, 16'd1024, "instruction count zero");
    wr(PCD_ADDR_INSTR, 8'hff);
    wr(PCD_ADDR_INTERP, 8'hf0);
    chk_rd(PCD_ADDR_INTERP, 8'h00);
    chk_out({5'h0, instr_o}, 16'd1020, "instruction count top");
    idle(1);
    chk_out({11'h0, interp_o}, 16'd16, "interpolation zero");
    wr(PCD_ADDR_INSTR, 8'h01);
    wr(PCD_ADDR_INTERP, 8'h0f);
    idle(2);
    chk_out({5'h0, instr_o}, 16'd4, "instruction count one");
    chk_out({11'h0, interp_o}, 16'd15, "interpolation fifteen");

    // Reserved registers keep reading zero; off-page reads give zero
    wr(PCD_ADDR_RSVD_B, 8'hff);
    wr(PCD_ADDR_RSVD_C, 8'hff);
    chk_rd(PCD_ADDR_RSVD_B, 8'h00);
    chk_rd(PCD_ADDR_RSVD_C, 8'h00);
    page_zero_i = 1'b0;
    chk_rd(PCD_ADDR_INSTR, 8'h00);
    page_zero_i = 1'b1;
    chk_rd(PCD_ADDR_INSTR, 8'h01);

    // Oversampling and instruction count both multiples of interpolation fifteen
    wr(PCD_ADDR_OSR_HI, 8'h00);
    wr(PCD_ADDR_OSR_LO, 8'h3c);
    wr(PCD_ADDR_INSTR, 8'h0f);
    idle(2);
    chk_out({5'h0, osr_o}, 16'h003c, "oversampling sixty");
    chk_out({5'h0, instr_o}, 16'h003c, "instruction count sixty");
    idle(1);
    end_of_test();
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    #20us;
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

endmodule : tb

// ===== verilog/pcd_clock_regs.sv
/*
  Playback clock chain configuration registers on the default page: fractional
  multiplier, coarse and fine playback dividers, oversampling ratio, processor
  instruction count and interpolation ratio, with decoded outputs.
  Assumes the serial control port decoder presents one-cycle write and read
  strobes on mclk_i and tells whether the default page is selected.
*/
// Function
// [RULE_01] Fraction low byte register, resets zero
// [RULE_02] Host writes fraction low right after high
// [RULE_03] Fraction high applied only on paired write
// [RULE_04] Host writes zeros to two reserved registers
// [RULE_05] Coarse divider bit seven powers it up
// [RULE_06] Coarse divider ratio field, zero means 128
// [RULE_07] Dividers reset powered down, divide by one
// [RULE_08] Fine divider bit seven powers it up
// [RULE_09] Fine divider ratio field, zero means 128
// [RULE_10] Ten-bit oversampling ratio, zero means 1024
// [RULE_11] Oversampling resets to ratio 128
// [RULE_12] Host writes oversampling low right after high
// [RULE_13] Host keeps oversampling multiple of interpolation
// [RULE_14] Instruction count four times field, zero 1024
// [RULE_15] Host keeps instructions multiple of interpolation
// [RULE_16] Interpolation four-bit field, zero means 16
// [RULE_17] Host avoids reserved register and upper bits
// [RULE_18] High parts staged, committed on next write
module pcd_clock_regs
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register access port
  input wire logic page_zero_i,
  input wire pcd_wr_t wr_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Decoded clock chain settings
  output logic [13:0] frac_o,
  output pcd_div_t coarse_o,
  output pcd_div_t fine_o,
  output logic [10:0] osr_o,
  output logic [10:0] instr_o,
  output logic [4:0] interp_o
);

  localparam pcd_main_t RST_STATE = '{
    coarse_reg: PCD_RST_DIV,
    fine_reg: PCD_RST_DIV,
    instr_reg: PCD_RST_INSTR,
    interp_reg: PCD_RST_INTERP,
    rd_data: 8'h00,
    rd_valid: 1'b0,
    frac: {PCD_RST_FRAC_HI[5:0], PCD_RST_FRAC_LO},
    coarse: pcd_div_decode(PCD_RST_DIV),
    fine: pcd_div_decode(PCD_RST_DIV),
    osr: pcd_osr_decode(PCD_RST_OSR_HI, PCD_RST_OSR_LO),
    instr: pcd_instr_decode(PCD_RST_INSTR),
    interp: pcd_interp_decode(PCD_RST_INTERP)
  };

  pcd_main_t st_q;
  pcd_main_t st_d;

  logic [7:0] frac_hi;
  logic [7:0] frac_lo;
  logic [7:0] osr_hi;
  logic [7:0] osr_lo;
  logic frac_armed;
  logic osr_armed;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic wr_hit(input pcd_wr_t w, input logic pz, input logic [6:0] a);
    return w.en && pz && (w.addr == a);
  endfunction : wr_hit

  // ==========================================================================
  // Split pairs
  // ==========================================================================
  pcd_split_commit #(
    .HI_MASK(PCD_MASK_FRAC_HI),
    .HI_RST(PCD_RST_FRAC_HI),
    .LO_RST(PCD_RST_FRAC_LO)
  ) u_frac (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(wr_i.en),
    .hi_sel_i(wr_hit(wr_i, page_zero_i, PCD_ADDR_FRAC_HI)),
    .lo_sel_i(wr_hit(wr_i, page_zero_i, PCD_ADDR_FRAC_LO)), // [RULE_01]
    .wdata_i(wr_i.data),
    .hi_o(frac_hi),
    .lo_o(frac_lo),
    .armed_o(frac_armed)
  );

  pcd_split_commit #(
    .HI_MASK(PCD_MASK_OSR_HI),
    .HI_RST(PCD_RST_OSR_HI),
    .LO_RST(PCD_RST_OSR_LO)
  ) u_osr (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(wr_i.en),
    .hi_sel_i(wr_hit(wr_i, page_zero_i, PCD_ADDR_OSR_HI)),
    .lo_sel_i(wr_hit(wr_i, page_zero_i, PCD_ADDR_OSR_LO)), // [RULE_11] [RULE_18]
    .wdata_i(wr_i.data),
    .hi_o(osr_hi),
    .lo_o(osr_lo),
    .armed_o(osr_armed)
  );

  // ==========================================================================
  // Register writes, read mux and decode
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    if (wr_hit(wr_i, page_zero_i, PCD_ADDR_COARSE)) begin
      st_d.coarse_reg = wr_i.data;
    end
    if (wr_hit(wr_i, page_zero_i, PCD_ADDR_FINE)) begin
      st_d.fine_reg = wr_i.data;
    end
    if (wr_hit(wr_i, page_zero_i, PCD_ADDR_INSTR)) begin
      st_d.instr_reg = wr_i.data;
    end
    if (wr_hit(wr_i, page_zero_i, PCD_ADDR_INTERP)) begin
      // Upper nibble is reserved and kept at zero
      st_d.interp_reg = wr_i.data & PCD_MASK_INTERP;
    end

    st_d.rd_valid = rd_en_i;
    st_d.rd_data = 8'h00;
    if (rd_en_i && page_zero_i) begin
      case (rd_addr_i)
        PCD_ADDR_FRAC_HI: st_d.rd_data = frac_hi;
        PCD_ADDR_FRAC_LO: st_d.rd_data = frac_lo;
        PCD_ADDR_COARSE: st_d.rd_data = st_q.coarse_reg;
        PCD_ADDR_FINE: st_d.rd_data = st_q.fine_reg;
        PCD_ADDR_OSR_HI: st_d.rd_data = osr_hi;
        PCD_ADDR_OSR_LO: st_d.rd_data = osr_lo;
        PCD_ADDR_INSTR: st_d.rd_data = st_q.instr_reg;
        PCD_ADDR_INTERP: st_d.rd_data = st_q.interp_reg;
        // Reserved and unmapped addresses read as zero
        default: st_d.rd_data = 8'h00;
      endcase
    end

    st_d.frac = {frac_hi[5:0], frac_lo}; // [RULE_03]
    st_d.coarse = pcd_div_decode(st_q.coarse_reg); // [RULE_05] [RULE_06]
    st_d.fine = pcd_div_decode(st_q.fine_reg); // [RULE_08] [RULE_09]
    st_d.osr = pcd_osr_decode(osr_hi, osr_lo); // [RULE_10]
    st_d.instr = pcd_instr_decode(st_q.instr_reg); // [RULE_14]
    st_d.interp = pcd_interp_decode(st_q.interp_reg); // [RULE_16]
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= RST_STATE; // [RULE_07] [RULE_11]
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rd_data_o = st_q.rd_data;
  assign rd_valid_o = st_q.rd_valid;
  assign frac_o = st_q.frac;
  assign coarse_o = st_q.coarse;
  assign fine_o = st_q.fine;
  assign osr_o = st_q.osr;
  assign instr_o = st_q.instr;
  assign interp_o = st_q.interp;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic w_frac_hi;
  logic w_frac_lo;
  logic w_coarse;
  logic w_fine;
  logic w_osr_hi;
  logic w_osr_lo;
  logic w_instr;
  logic w_interp;
  logic rd_rsvd;

  assign w_frac_hi = wr_hit(wr_i, page_zero_i, PCD_ADDR_FRAC_HI);
  assign w_frac_lo = wr_hit(wr_i, page_zero_i, PCD_ADDR_FRAC_LO);
  assign w_coarse = wr_hit(wr_i, page_zero_i, PCD_ADDR_COARSE);
  assign w_fine = wr_hit(wr_i, page_zero_i, PCD_ADDR_FINE);
  assign w_osr_hi = wr_hit(wr_i, page_zero_i, PCD_ADDR_OSR_HI);
  assign w_osr_lo = wr_hit(wr_i, page_zero_i, PCD_ADDR_OSR_LO);
  assign w_instr = wr_hit(wr_i, page_zero_i, PCD_ADDR_INSTR);
  assign w_interp = wr_hit(wr_i, page_zero_i, PCD_ADDR_INTERP);
  assign rd_rsvd = rd_en_i && page_zero_i &&
    (rd_addr_i == PCD_ADDR_RSVD_A || rd_addr_i == PCD_ADDR_RSVD_B || rd_addr_i == PCD_ADDR_RSVD_C);

  a_frac_lo_write: assert property (w_frac_lo |-> ##2 frac_o[7:0] == $past(wr_i.data, 2)) // [RULE_01]
    else $error("fraction low byte not applied");

  a_frac_pair_commit: assert property ((w_frac_hi ##1 w_frac_lo) |-> ##2 frac_o[13:8] == $past(wr_i.data[5:0], 3)) // [RULE_03]
    else $error("paired fraction high write not committed");

  a_frac_unpaired: assert property ((w_frac_hi ##1 (wr_i.en && !w_frac_lo)) |-> ##2 $stable(frac_o[13:8])) // [RULE_18]
    else $error("unpaired fraction high write took effect");

  a_osr_pair_commit: assert property ((w_osr_hi ##1 w_osr_lo) |-> // [RULE_10]
    ##2 osr_o == pcd_osr_decode($past(wr_i.data, 3), $past(wr_i.data, 2)))
    else $error("paired oversampling write decoded wrongly");

  a_osr_range: assert property (osr_o != 11'h000 && osr_o <= PCD_OSR_ZERO_RATIO) // [RULE_10]
    else $error("oversampling ratio out of range");

  a_coarse_power: assert property (w_coarse |-> ##2 coarse_o.pwr == $past(wr_i.data[PCD_DIV_PWR_BIT], 2)) // [RULE_05]
    else $error("coarse divider power bit not applied");

  a_coarse_zero: assert property ((w_coarse && wr_i.data[6:0] == 7'h00) |-> // [RULE_06]
    ##2 coarse_o.ratio == PCD_DIV_ZERO_RATIO)
    else $error("coarse divider zero field not 128");

  a_fine_power: assert property (w_fine |-> ##2 fine_o.pwr == $past(wr_i.data[PCD_DIV_PWR_BIT], 2)) // [RULE_08]
    else $error("fine divider power bit not applied");

  a_fine_ratio: assert property (w_fine |-> // [RULE_09]
    ##2 fine_o == pcd_div_decode($past(wr_i.data, 2)) && fine_o.ratio != 8'h00)
    else $error("fine divider ratio wrong");

  a_instr_scale: assert property ((w_instr && wr_i.data != 8'h00) |-> // [RULE_14]
    ##2 instr_o == {1'b0, $past(wr_i.data, 2), 2'b00})
    else $error("instruction count not four times field");

  a_interp_ratio: assert property (w_interp |-> ##2 interp_o == pcd_interp_decode($past(wr_i.data, 2))) // [RULE_16]
    else $error("interpolation ratio wrong");

  a_rsvd_read: assert property (rd_rsvd |=> rd_valid_o && rd_data_o == 8'h00)
    else $error("reserved register read not zero");

  // ==========================================================================
  // Pair staging, field ranges and read port
  // ==========================================================================
  a_frac_arm: assert property (w_frac_hi |=> frac_armed) // [RULE_18]
    else $error("fraction high write not staged");

  a_frac_disarm: assert property ((frac_armed && wr_i.en && !w_frac_hi) |=> !frac_armed) // [RULE_18]
    else $error("fraction staging survived another write");

  a_osr_arm: assert property (w_osr_hi |=> osr_armed) // [RULE_18]
    else $error("oversampling high write not staged");

  a_osr_disarm: assert property ((osr_armed && wr_i.en && !w_osr_hi) |=> !osr_armed) // [RULE_18]
    else $error("oversampling staging survived another write");

  a_osr_unpaired: assert property ((w_osr_hi ##1 (wr_i.en && !w_osr_lo)) |=> $stable(osr_hi)) // [RULE_18]
    else $error("unpaired oversampling high write took effect");

  a_frac_hi_mask: assert property ((frac_hi & ~PCD_MASK_FRAC_HI) == 8'h00) // [RULE_03]
    else $error("fraction high reserved bits set");

  a_osr_hi_mask: assert property ((osr_hi & ~PCD_MASK_OSR_HI) == 8'h00) // [RULE_10]
    else $error("oversampling high reserved bits set");

  a_coarse_ratio: assert property ((w_coarse && wr_i.data[6:0] != 7'h00) |-> // [RULE_06]
    ##2 coarse_o.ratio == {1'h0, $past(wr_i.data[6:0], 2)})
    else $error("coarse divider ratio field not applied");

  a_fine_zero: assert property ((w_fine && wr_i.data[6:0] == 7'h00) |-> // [RULE_09]
    ##2 fine_o.ratio == PCD_DIV_ZERO_RATIO)
    else $error("fine divider zero field not 128");

  a_div_range: assert property (coarse_o.ratio != 8'h00 && coarse_o.ratio <= PCD_DIV_ZERO_RATIO) // [RULE_06]
    else $error("coarse divider ratio out of range");

  a_instr_zero: assert property ((w_instr && wr_i.data == 8'h00) |-> ##2 instr_o == PCD_INSTR_ZERO_COUNT) // [RULE_14]
    else $error("instruction count zero field not 1024");

  a_instr_range: assert property (instr_o != 11'h000 && instr_o[1:0] == 2'h0 && instr_o <= PCD_INSTR_ZERO_COUNT) // [RULE_14]
    else $error("instruction count out of range");

  a_interp_range: assert property (interp_o != 5'h00 && interp_o <= PCD_INTERP_ZERO_RATIO) // [RULE_16]
    else $error("interpolation ratio out of range");

  a_rd_answer: assert property (rd_en_i |=> rd_valid_o) // [RULE_01]
    else $error("read not answered");

  a_rd_idle: assert property (!rd_en_i |=> !rd_valid_o && rd_data_o == 8'h00) // [RULE_01]
    else $error("read data not cleared outside a read");

  c_frac_pair: cover property (w_frac_hi ##1 w_frac_lo);
  c_osr_max: cover property (osr_o == PCD_OSR_ZERO_RATIO);
  c_coarse_128: cover property (coarse_o.ratio == PCD_DIV_ZERO_RATIO && coarse_o.pwr);
  c_interp_16: cover property (interp_o == PCD_INTERP_ZERO_RATIO);
  c_osr_broken: cover property (w_osr_hi ##1 (wr_i.en && !w_osr_lo));

endmodule : pcd_clock_regs

// ===== verilog/pcd_split_commit.sv
/*
  High/low register pair whose high part is staged and committed only when the
  low part is the very next register write. Assumes every register write of the
  port, on any page or address, is flagged on wr_en_i in the same clock domain.
*/
module pcd_split_commit
  import pcd_pkg::*;
#(
  parameter logic [7:0] HI_MASK = 8'hff,
  parameter logic [7:0] HI_RST = 8'h00,
  parameter logic [7:0] LO_RST = 8'h00
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic hi_sel_i,
  input wire logic lo_sel_i,
  input wire logic [7:0] wdata_i,
  // Committed pair
  output logic [7:0] hi_o,
  output logic [7:0] lo_o,
  output logic armed_o
);

  localparam pcd_split_t RST_STATE = '{state: PCD_SPLIT_IDLE, staged: HI_RST, hi: HI_RST, lo: LO_RST};

  pcd_split_t s_q;
  pcd_split_t s_d;

  // ==========================================================================
  // Staging and commit
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    if (wr_en_i && hi_sel_i) begin
      s_d.staged = wdata_i & HI_MASK; // [RULE_18]
    end
    if (wr_en_i && lo_sel_i) begin
      s_d.lo = wdata_i;
    end
    case (s_q.state)
      PCD_SPLIT_IDLE: begin
        if (wr_en_i && hi_sel_i) begin
          s_d.state = PCD_SPLIT_ARMED;
        end
      end
      PCD_SPLIT_ARMED: begin
        if (wr_en_i) begin
          // Any other write in between, except a new high write, disarms, so the high part is dropped
          if (lo_sel_i) begin
            s_d.hi = s_q.staged; // [RULE_03] [RULE_18]
          end
          s_d.state = hi_sel_i ? PCD_SPLIT_ARMED : PCD_SPLIT_IDLE;
        end
      end
      default: begin
        s_d.state = PCD_SPLIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hi_o = s_q.hi;
  assign lo_o = s_q.lo;
  assign armed_o = (s_q.state == PCD_SPLIT_ARMED);

endmodule : pcd_split_commit
